// ---- scfp_pkg.sv ----
/*
 * scfp_pkg: constants for the system configuration and flash protection block.
 * Assumes a 24-bit Avalon-MM byte address and 32-bit data words.
 */
package scfp_pkg;
    // ========================================
    // bus geometry
    localparam int          SCFP_ADDR_W        = 24;             // byte address width
    localparam int          SCFP_DATA_W        = 32;             // bus data width
    // ========================================
    // register byte addresses
    localparam logic [23:0] SCFP_MODULE_CONFIG = 24'hfff910;     // configuration
    localparam logic [23:0] SCFP_MODULE_STATUS = 24'hfff914;     // status, read only
    localparam logic [23:0] SCFP_PROG_WE_LOW   = 24'hfff918;     // program sections 0..15
    localparam logic [23:0] SCFP_PROG_WE_HIGH  = 24'hfff91c;     // program sections 16..31
    localparam logic [23:0] SCFP_DATA_WE       = 24'hfff920;     // data sections 0..15
    // ========================================
    // reset values
    localparam logic [7:0]  SCFP_CONFIG_RST    = 8'h10;          // transceiver enable set
    localparam logic [15:0] SCFP_SECT_WE_RST   = 16'h0000;       // all sections locked
    // ========================================
    // configuration field positions
    localparam int          SCFP_CFG_EXT_IO    = 0;              // ext_io_zone_bus_en
    localparam int          SCFP_CFG_PLL_OE    = 1;              // pll_clock_out_en
    localparam int          SCFP_CFG_MAIN_OE   = 2;              // main_clock_out_en
    localparam int          SCFP_CFG_SLOW_OE   = 3;              // slow_clock_out_en
    localparam int          SCFP_CFG_USB_EN    = 4;              // transceiver enable
    localparam int          SCFP_CFG_MISC_SLEW = 5;              // misc pad slow slew
    localparam int          SCFP_CFG_MEM_SLEW  = 6;              // memory pad slow slew
    localparam logic [7:0]  SCFP_CFG_WMASK     = 8'h7f;          // bit 7 reserved
    // ========================================
    // status field positions
    localparam int          SCFP_ST_ANY_BUSY   = 3;              // flash_any_busy
    localparam int          SCFP_ST_DATA_BUSY  = 4;              // data_flash_busy
    // ========================================
    // flash map
    localparam logic [23:0] SCFP_PROG_BASE     = 24'h000000;     // program flash start
    localparam logic [23:0] SCFP_PROG_LAST     = 24'h03ffff;     // program flash end
    localparam logic [23:0] SCFP_DATA_BASE     = 24'h0e0000;     // data flash start
    localparam logic [23:0] SCFP_DATA_LAST     = 24'h0e1fff;     // data flash end
    localparam logic [23:0] SCFP_BOOT_LIMIT    = 24'h001c00;     // first byte past max boot
    localparam int          SCFP_PROG_SECT_LSB = 13;             // 8K-byte sections
    localparam int          SCFP_DATA_SECT_LSB = 9;              // 512-byte sections
    localparam int          SCFP_LOCK_W        = 3;              // voted lock field width
endpackage : scfp_pkg

// ---- scfp_lock_vote.sv ----
/*
 * scfp_lock_vote: majority vote over one lock field of the protection word.
 * Assumes the field is already latched and stable between resets.
 */
`timescale 1ns/10ps
module scfp_lock_vote #(
    parameter int W = 3
) (
    // latched lock field
    input  wire logic [W-1:0] lock_bits,
    // protection active when most bits are clear
    output      logic         lock_active
);
    // ========================================
    // count of cleared bits
    logic [7:0] zeros;  // wide enough for any sane field

    always_comb begin
        zeros = 8'h00;
        for (int i = 0; i < W; i++) begin
            if (!lock_bits[i]) begin
                zeros = zeros + 8'h01;
            end
        end
    end

    // for W of 3 or more, a single flipped bit cannot change the verdict when all W bits agree
    assign lock_active = (zeros > 8'(W / 2));

endmodule : scfp_lock_vote

// ---- scfp_top.sv ----
/*
 * scfp_top: system configuration, module status and flash write protection.
 * Assumes an Avalon-MM master, flash controllers that report busy levels,
 * and a protection word presented on ports that is valid while rst is high.
 */
// Overview of operation
// - read/write 8-bit configuration register at fff910
// - configuration kept across all power modes
// - bit 0 enables external I/O zone bus
// - bits 1-3 drive clocks onto strap pins
// - bit 4 clear forces transceiver low power
// - bit 5 selects slow slew, misc pads
// - bit 6 slow slew memory pads; 7 reserved
// - read-only 8-bit status at fff914, 7:5 reserved
// - status 2:0 hold straps sampled at reset
// - status bit 3 mirrors program controller busy
// - status bit 4 mirrors data flash busy
// - boot area from zero to clamped end
// - boot area writes always rejected
// - code/data writes need enable, no lock
// - 8K program sections, 512-byte data sections
// - section enables clear at reset
// - write lock active on majority zeros
// - read lock blocks debug reads on majority zeros
// - protection word changes apply after reset
`timescale 1ns/10ps
module scfp_top
    import scfp_pkg::*;
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // avalon-mm slave
    input  wire logic [scfp_pkg::SCFP_ADDR_W-1:0] address,
    input  wire logic                          read,
    input  wire logic                          write,
    input  wire logic [3:0]                    byteenable,
    input  wire logic [scfp_pkg::SCFP_DATA_W-1:0] writedata,
    output      logic [scfp_pkg::SCFP_DATA_W-1:0] readdata,
    output      logic                          waitrequest,
    // strap pins, shared with clock outputs
    input  wire logic [2:0]                    strap_pins_in,
    output      logic [2:0]                    strap_pins_out,
    output      logic [2:0]                    strap_pins_oe,
    // clocks offered to the strap pins
    input  wire logic                          pll_clk_src,
    input  wire logic                          main_clk_src,
    input  wire logic                          slow_clk_src,
    // configuration outputs
    output      logic                          ext_io_zone_bus_en,
    output      logic                          usb_xcvr_active,
    output      logic                          misc_pad_slow_slew,
    output      logic                          mem_pad_slow_slew,
    // transceiver power inputs
    input  wire logic                          usb_ctrl_active,
    input  wire logic                          func_word_usb_en,
    // flash controller busy flags
    input  wire logic                          prog_flash_ctrl_busy,
    input  wire logic                          data_flash_ctrl_busy,
    // protection word, sampled during reset
    input  wire logic [2:0]                    prot_write_lock,
    input  wire logic [2:0]                    prot_read_lock,
    input  wire logic [23:0]                   prot_boot_end,
    // cpu flash access check
    input  wire logic                          fl_req,
    input  wire logic                          fl_wr,
    input  wire logic [23:0]                   fl_addr,
    output      logic                          fl_allow,
    output      logic                          fl_reject,
    // debug and programmer read block
    output      logic                          debug_read_block
);
    import scfp_pkg::*;

    // ========================================
    // bus handshake
    logic        ack_q;        // high in the cycle the request completes
    logic        ack_d;
    logic        req;          // any request present
    logic        wr_take;      // write accepted this edge
    logic [21:0] word_addr;    // word index of the request

    // one wait cycle for every access, keeps decode off the fast path
    assign req         = read | write;
    assign ack_d       = req & ~ack_q;
    assign waitrequest = req & ~ack_q;
    assign wr_take     = write & ack_q;
    assign word_addr   = address[23:2];

    // ack pulses once per request
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    // ========================================
    // address decode
    wire sel_cfg  = (word_addr == SCFP_MODULE_CONFIG[23:2]);
    wire sel_stat = (word_addr == SCFP_MODULE_STATUS[23:2]);
    wire sel_pwl  = (word_addr == SCFP_PROG_WE_LOW[23:2]);
    wire sel_pwh  = (word_addr == SCFP_PROG_WE_HIGH[23:2]);
    wire sel_dwe  = (word_addr == SCFP_DATA_WE[23:2]);

    // ========================================
    // configuration register
    logic [7:0] cfg_q;  // module_config
    logic [7:0] cfg_d;

    // only reset and a bus write change it; no power mode touches it
    assign cfg_d = (wr_take && sel_cfg && byteenable[0]) ? (writedata[7:0] & SCFP_CFG_WMASK) : cfg_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= SCFP_CONFIG_RST;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ========================================
    // configuration effects
    assign ext_io_zone_bus_en = cfg_q[SCFP_CFG_EXT_IO];
    // clocks pass straight through; a flop here would halve them
    assign strap_pins_out     = {slow_clk_src, main_clk_src, pll_clk_src};
    assign strap_pins_oe      = {cfg_q[SCFP_CFG_SLOW_OE], cfg_q[SCFP_CFG_MAIN_OE], cfg_q[SCFP_CFG_PLL_OE]};
    // clear bit overrides controller and function word
    assign usb_xcvr_active    = cfg_q[SCFP_CFG_USB_EN] & usb_ctrl_active & func_word_usb_en;
    assign misc_pad_slow_slew = cfg_q[SCFP_CFG_MISC_SLEW];
    assign mem_pad_slow_slew  = cfg_q[SCFP_CFG_MEM_SLEW];

    // ========================================
    // strap capture
    logic [2:0] strap_state_q;  // levels seen during reset

    // sampled every reset cycle, frozen once reset is released
    always_ff @(posedge clk) begin
        if (rst) begin
            strap_state_q <= strap_pins_in;
        end
    end

    // ========================================
    // status word
    logic [7:0] status;  // module_status
    assign status = {3'b000, data_flash_ctrl_busy, prog_flash_ctrl_busy, strap_state_q};

    // ========================================
    // section write enables
    logic [15:0] pwl_q;  // prog_section_we_low
    logic [15:0] pwh_q;  // prog_section_we_high
    logic [15:0] dwe_q;  // data_section_we
    logic [15:0] pwl_d;
    logic [15:0] pwh_d;
    logic [15:0] dwe_d;
    logic [15:0] be_mask;  // byte lanes 0 and 1

    assign be_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
    assign pwl_d   = (wr_take && sel_pwl) ? ((writedata[15:0] & be_mask) | (pwl_q & ~be_mask)) : pwl_q;
    assign pwh_d   = (wr_take && sel_pwh) ? ((writedata[15:0] & be_mask) | (pwh_q & ~be_mask)) : pwh_q;
    assign dwe_d   = (wr_take && sel_dwe) ? ((writedata[15:0] & be_mask) | (dwe_q & ~be_mask)) : dwe_q;

    // all sections locked out of reset
    always_ff @(posedge clk) begin
        if (rst) begin
            pwl_q <= SCFP_SECT_WE_RST;
            pwh_q <= SCFP_SECT_WE_RST;
            dwe_q <= SCFP_SECT_WE_RST;
        end else begin
            pwl_q <= pwl_d;
            pwh_q <= pwh_d;
            dwe_q <= dwe_d;
        end
    end

    // ========================================
    // read data
    logic [31:0] rdata_q;  // held for the answer cycle
    logic [31:0] rdata_d;
    logic [7:0]  rsel;

    // unmapped addresses read as zero
    assign rsel    = sel_cfg  ? cfg_q  :
                     sel_stat ? status : 8'h00;
    assign rdata_d = (sel_pwl) ? {16'h0000, pwl_q} :
                     (sel_pwh) ? {16'h0000, pwh_q} :
                     (sel_dwe) ? {16'h0000, dwe_q} : {24'h000000, rsel};

    // loaded at the edge that raises ack, so it stands when waitrequest drops
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else if (read && !ack_q) begin
            rdata_q <= rdata_d;
        end
    end
    assign readdata = rdata_q;

    // ========================================
    // protection word latch
    logic [2:0]  wlock_q;     // write lock field
    logic [2:0]  rlock_q;     // read lock field
    logic [23:0] boot_lim_q;  // first byte of the code area

    // later writes to the stored word wait for the next reset
    always_ff @(posedge clk) begin
        if (rst) begin
            wlock_q    <= prot_write_lock;
            rlock_q    <= prot_read_lock;
            boot_lim_q <= (prot_boot_end > SCFP_BOOT_LIMIT) ? SCFP_BOOT_LIMIT : prot_boot_end;
        end
    end

    // ========================================
    // global locks
    logic glob_wlock;  // write protection active
    logic glob_rlock;  // read protection active

    scfp_lock_vote #(.W(SCFP_LOCK_W)) u_wvote (
        .lock_bits   (wlock_q),
        .lock_active (glob_wlock)
    );

    scfp_lock_vote #(.W(SCFP_LOCK_W)) u_rvote (
        .lock_bits   (rlock_q),
        .lock_active (glob_rlock)
    );

    // cpu reads are never gated by this
    assign debug_read_block = glob_rlock;

    // ========================================
    // access check
    wire        in_prog  = (fl_addr <= SCFP_PROG_LAST);
    wire        in_data  = (fl_addr >= SCFP_DATA_BASE) && (fl_addr <= SCFP_DATA_LAST);
    wire        in_boot  = in_prog && (fl_addr < boot_lim_q);
    wire [4:0]  psect    = fl_addr[17:SCFP_PROG_SECT_LSB];
    wire [3:0]  dsect    = fl_addr[12:SCFP_DATA_SECT_LSB];
    wire [31:0] pwe_all  = {pwh_q, pwl_q};
    wire        sect_ok  = in_prog ? pwe_all[psect] : (in_data ? dwe_q[dsect] : 1'b0);
    // boot area refusal outranks enables and locks
    wire        wr_ok    = !in_boot && sect_ok && !glob_wlock;
    wire        ok       = fl_wr ? wr_ok : (in_prog || in_data);

    logic allow_q;   // one-cycle verdict pulses
    logic reject_q;

    // verdict one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            allow_q  <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            allow_q  <= fl_req & ok;
            reject_q <= fl_req & ~ok;
        end
    end
    assign fl_allow  = allow_q;
    assign fl_reject = reject_q;

    // ========================================
    // checks
    sequence s_cfg_wr;
        write && ack_q && sel_cfg && byteenable[0];
    endsequence

    sequence s_stat_rd;
        read && !ack_q && sel_stat;
    endsequence

    sequence s_boot_wr;
        fl_req && fl_wr && in_boot;
    endsequence

    sequence s_fl_wr;
        fl_req && fl_wr;
    endsequence

    // reset and bus side
    chk_cfg_after_reset: assert property (@(posedge clk) $fell(rst) |-> cfg_q == 8'h10)
        else $error("config reset value wrong");
    chk_cfg_write_lands: assert property (@(posedge clk) disable iff (rst)
        s_cfg_wr |=> cfg_q == ($past(writedata[7:0]) & 8'h7f))
        else $error("config write lost");
    chk_clock_pin_oe: assert property (@(posedge clk) disable iff (rst)
        s_cfg_wr |=> strap_pins_oe == $past(writedata[3:1]))
        else $error("strap pin enable mismatch");
    chk_ext_io_bit: assert property (@(posedge clk) disable iff (rst)
        s_cfg_wr |=> ext_io_zone_bus_en == $past(writedata[0]))
        else $error("external bus enable mismatch");
    chk_slew_bits: assert property (@(posedge clk) disable iff (rst)
        s_cfg_wr |=> {mem_pad_slow_slew, misc_pad_slow_slew} == $past(writedata[6:5]))
        else $error("slew select mismatch");
    // a cleared enable must win over both power inputs
    chk_usb_forced: assert property (@(posedge clk) disable iff (rst)
        s_cfg_wr ##0 !writedata[4] |=> !usb_xcvr_active)
        else $error("transceiver not forced low");
    chk_status_mirror: assert property (@(posedge clk) disable iff (rst)
        s_stat_rd |=> readdata[4:3] == {$past(data_flash_ctrl_busy), $past(prog_flash_ctrl_busy)})
        else $error("busy mirror wrong");
    chk_status_resvd: assert property (@(posedge clk) disable iff (rst)
        s_stat_rd |=> readdata[7:5] == 3'b000 && !waitrequest)
        else $error("status reserved bits set");
    chk_strap_held: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> $stable(strap_state_q))
        else $error("strap state changed");
    chk_lock_frozen: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> $stable(wlock_q) && $stable(boot_lim_q))
        else $error("protection latch changed");
    chk_boot_clamp: assert property (@(posedge clk) disable iff (rst)
        boot_lim_q <= SCFP_BOOT_LIMIT)
        else $error("boot end past maximum");
    // protection side
    chk_boot_reject: assert property (@(posedge clk) disable iff (rst)
        s_boot_wr |=> fl_reject && !fl_allow)
        else $error("boot write not rejected");
    chk_glock_reject: assert property (@(posedge clk) disable iff (rst)
        s_fl_wr ##0 glob_wlock |=> fl_reject)
        else $error("locked write not rejected");
    chk_sect_allow: assert property (@(posedge clk) disable iff (rst)
        s_fl_wr ##0 in_data && dwe_q[dsect] && !glob_wlock |=> fl_allow)
        else $error("enabled data write rejected");
    chk_one_verdict: assert property (@(posedge clk) disable iff (rst)
        fl_req |=> fl_allow != fl_reject)
        else $error("verdict not exactly one");
    chk_sect_reset: assert property (@(posedge clk) $fell(rst) |-> {pwl_q, pwh_q, dwe_q} == 48'h0)
        else $error("section enables not cleared");
    chk_read_vote: assert property (@(posedge clk) disable iff (rst)
        debug_read_block == ((rlock_q == 3'b000) || (rlock_q == 3'b001) || (rlock_q == 3'b010) || (rlock_q == 3'b100)))
        else $error("read lock vote wrong");
    chk_write_vote: assert property (@(posedge clk) disable iff (rst)
        glob_wlock == ((wlock_q == 3'b000) || (wlock_q == 3'b001) || (wlock_q == 3'b010) || (wlock_q == 3'b100)))
        else $error("write lock vote wrong");

endmodule : scfp_top

// ---- sys_config_flash_protect_test.sv ----
/*
 * sys_config_flash_protect_test: self-checking bench for scfp_top.
 * Assumes scfp_pkg and scfp_top are compiled first; the bench drives every port itself.
 */
`timescale 1ns/10ps
module sys_config_flash_protect_test;
    import scfp_pkg::*;
    // ========================================
    // stimulus and observed signals
    logic        clk                  = 1'b0;       // 100 MHz
    logic        rst                  = 1'b1;       // sync, active high
    logic [23:0] address              = 24'h000000; // bus address
    logic        read                 = 1'b0;       // bus read
    logic        write                = 1'b0;       // bus write
    logic [3:0]  byteenable           = 4'hf;       // all lanes
    logic [31:0] writedata            = 32'h00000000;
    logic [31:0] readdata;                          // slave read data
    logic        waitrequest;                       // slave stall
    logic [2:0]  strap_pins_in        = 3'h5;       // sampled during reset
    logic [2:0]  strap_pins_out;                    // clock pass-through
    logic [2:0]  strap_pins_oe;                     // clock output enables
    logic        pll_clk_src          = 1'b1;       // static levels suffice
    logic        main_clk_src         = 1'b0;
    logic        slow_clk_src         = 1'b1;
    logic        ext_io_zone_bus_en;
    logic        usb_xcvr_active;
    logic        misc_pad_slow_slew;
    logic        mem_pad_slow_slew;
    logic        usb_ctrl_active      = 1'b1;
    logic        func_word_usb_en     = 1'b1;
    logic        prog_flash_ctrl_busy = 1'b0;
    logic        data_flash_ctrl_busy = 1'b0;
    logic [2:0]  prot_write_lock      = 3'h6;       // majority set: unlocked
    logic [2:0]  prot_read_lock       = 3'h3;       // majority set: unlocked
    logic [23:0] prot_boot_end        = 24'h002000; // past the max, so clamped
    logic        fl_req               = 1'b0;
    logic        fl_wr                = 1'b0;
    logic [23:0] fl_addr              = 24'h000000;
    logic        fl_allow;
    logic        fl_reject;
    logic        debug_read_block;
    int          miscompares          = 0;          // mismatches seen
    int          checked              = 0;          // comparisons made
    int          cycles               = 0;          // hang guard

    scfp_top scfp_top_inst (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .strap_pins_in(strap_pins_in), .strap_pins_out(strap_pins_out), .strap_pins_oe(strap_pins_oe),
        .pll_clk_src(pll_clk_src), .main_clk_src(main_clk_src), .slow_clk_src(slow_clk_src),
        .ext_io_zone_bus_en(ext_io_zone_bus_en), .usb_xcvr_active(usb_xcvr_active),
        .misc_pad_slow_slew(misc_pad_slow_slew), .mem_pad_slow_slew(mem_pad_slow_slew),
        .usb_ctrl_active(usb_ctrl_active), .func_word_usb_en(func_word_usb_en),
        .prog_flash_ctrl_busy(prog_flash_ctrl_busy), .data_flash_ctrl_busy(data_flash_ctrl_busy),
        .prot_write_lock(prot_write_lock), .prot_read_lock(prot_read_lock), .prot_boot_end(prot_boot_end),
        .fl_req(fl_req), .fl_wr(fl_wr), .fl_addr(fl_addr), .fl_allow(fl_allow), .fl_reject(fl_reject),
        .debug_read_block(debug_read_block));

    // ========================================
    // clock and hang guard
    always #5 clk = ~clk;

    // whole run is under two hundred cycles, so this ceiling only trips on a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    // ========================================
    // helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one avalon cycle: request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [23:0] addr, input logic [31:0] data, output logic [31:0] got);
        @(posedge clk);
        address   <= addr;
        writedata <= data;
        read      <= ~wr;
        write     <= wr;
        // waitrequest is read at the edge, before that edge's updates land
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        got = readdata;   // still standing at the completing edge
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [23:0] addr, input logic [31:0] data);
        logic [31:0] junk;
        bus(1'b1, addr, data, junk);
    endtask : wr

    task automatic rd_chk(input string what, input logic [23:0] addr, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, addr, 32'h00000000, got);
        check(what, got, exp);
    endtask : rd_chk

    // verdict is registered: look one cycle after the request edge
    task automatic fl_chk(input logic is_wr, input logic [23:0] a, input logic ok);
        @(posedge clk);
        fl_req  <= 1'b1;
        fl_wr   <= is_wr;
        fl_addr <= a;
        @(posedge clk);
        fl_req <= 1'b0;
        @(posedge clk);
        check("fl_allow", {31'h0, fl_allow}, {31'h0, ok});
        check("fl_reject", {31'h0, fl_reject}, {31'h0, ~ok});
    endtask : fl_chk

    // protection word is taken while rst is high
    task automatic do_reset(input logic [2:0] wl, input logic [2:0] rl, input logic [23:0] be);
        @(posedge clk);
        rst             <= 1'b1;
        prot_write_lock <= wl;
        prot_read_lock  <= rl;
        prot_boot_end   <= be;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // ========================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst           <= 1'b0;
        strap_pins_in <= 3'h2;   // late change must not reach status
        rd_chk("config reset", SCFP_MODULE_CONFIG, 32'h10);
        rd_chk("prog we reset", SCFP_PROG_WE_LOW, 32'h0);
        rd_chk("data we reset", SCFP_DATA_WE, 32'h0);
        rd_chk("unmapped read", 24'hfff924, 32'h0);
        wr(SCFP_MODULE_CONFIG, 32'hff);
        rd_chk("config reserved", SCFP_MODULE_CONFIG, 32'h7f);
        check("strap out", {29'h0, strap_pins_out}, 32'h5);
        // walk bits 0 to 6; the transceiver is forced low whenever bit 4 is clear
        for (int i = 0; i < 7; i++) begin
            wr(SCFP_MODULE_CONFIG, 32'h1 << i);
            #1;
            check("config pins", {25'h0, mem_pad_slow_slew, misc_pad_slow_slew, usb_xcvr_active,
                strap_pins_oe, ext_io_zone_bus_en}, 32'h1 << i);
            rd_chk("config bit", SCFP_MODULE_CONFIG, 32'h1 << i);
        end
        wr(SCFP_MODULE_CONFIG, 32'h10);
        usb_ctrl_active <= 1'b0;
        #1;
        check("usb follows ctrl", {31'h0, usb_xcvr_active}, 32'h0);
        @(posedge clk);
        usb_ctrl_active  <= 1'b1;
        func_word_usb_en <= 1'b0;
        #1;
        check("usb follows word", {31'h0, usb_xcvr_active}, 32'h0);
        @(posedge clk);
        func_word_usb_en <= 1'b1;
        #1;
        check("usb enabled", {31'h0, usb_xcvr_active}, 32'h1);
        // status: straps held, write ignored, busy mirrors
        wr(SCFP_MODULE_STATUS, 32'hff);
        rd_chk("status idle", SCFP_MODULE_STATUS, 32'h05);
        prog_flash_ctrl_busy <= 1'b1;
        rd_chk("status prog busy", SCFP_MODULE_STATUS, 32'h0d);
        prog_flash_ctrl_busy <= 1'b0;
        data_flash_ctrl_busy <= 1'b1;
        rd_chk("status data busy", SCFP_MODULE_STATUS, 32'h15);
        data_flash_ctrl_busy <= 1'b0;
        // sections: program 0, program 31, data 1 enabled
        wr(SCFP_PROG_WE_LOW, 32'h0001);
        wr(SCFP_PROG_WE_HIGH, 32'h8000);
        wr(SCFP_DATA_WE, 32'h0002);
        fl_chk(1'b1, 24'h000000, 1'b0);
        fl_chk(1'b1, 24'h001bff, 1'b0);
        fl_chk(1'b1, 24'h001c00, 1'b1);
        fl_chk(1'b1, 24'h002000, 1'b0);
        fl_chk(1'b1, 24'h03e000, 1'b1);
        fl_chk(1'b1, 24'h0e0200, 1'b1);
        fl_chk(1'b1, 24'h0e03ff, 1'b1);
        fl_chk(1'b1, 24'h0e0400, 1'b0);
        fl_chk(1'b0, 24'h002000, 1'b1);
        fl_chk(1'b0, 24'h0f0000, 1'b0);
        wr(SCFP_DATA_WE, 32'h0000);
        fl_chk(1'b1, 24'h0e0200, 1'b0);
        check("read block off", {31'h0, debug_read_block}, 32'h0);
        // lock word changed without reset: no effect yet
        prot_write_lock <= 3'h1;
        fl_chk(1'b1, 24'h001c00, 1'b1);
        // smaller boot end, read lock on
        do_reset(3'h6, 3'h4, 24'h000400);
        rd_chk("prog we cleared", SCFP_PROG_WE_LOW, 32'h0);
        rd_chk("status straps", SCFP_MODULE_STATUS, 32'h02);
        wr(SCFP_PROG_WE_LOW, 32'h0001);
        fl_chk(1'b1, 24'h0003ff, 1'b0);
        fl_chk(1'b1, 24'h000400, 1'b1);
        check("read block on", {31'h0, debug_read_block}, 32'h1);
        fl_chk(1'b0, 24'h000000, 1'b1);
        // write lock by majority zero
        do_reset(3'h2, 3'h7, 24'h000400);
        wr(SCFP_PROG_WE_LOW, 32'h0001);
        wr(SCFP_DATA_WE, 32'h0002);
        fl_chk(1'b1, 24'h000400, 1'b0);
        fl_chk(1'b1, 24'h0e0200, 1'b0);
        check("read block off", {31'h0, debug_read_block}, 32'h0);
        stop_test();
    end
endmodule : sys_config_flash_protect_test
